// ===== design/pbg_pkg.sv
// package of the sixteen-line port: register map, field layout, reset values, timing
// assumes a 125 MHz clock and a 32-bit AXI4-Lite register bus
package pbg_pkg;
   localparam int PORT_W = 16;
   localparam int IRQ_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int TOP_LINE = 15;
   // ************************************
   // register byte offsets
   // ************************************
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DOUT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_DIN = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_EDGE_SEL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_OSC_STAT = 8'h18;
   // ************************************
   // reset values and fields
   // ************************************
   localparam logic [PORT_W-1:0] RST_DIR = 16'h0000;
   localparam logic [PORT_W-1:0] RST_DOUT = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_EDGE_SEL = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ_STAT = 8'h00;
   localparam logic [PORT_W-1:0] TOP_MASK = 16'h8000;
   localparam int OSC_LF_BIT = 0;
   localparam int OSC_DONE_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************
   // strap capture timing
   // ************************************
   localparam logic [1:0] STRAP_SAMPLE_CNT = 2'h3;
endpackage

// ===== design/pbg_edge_if.sv
// interface between the port core and its line sampler
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface pbg_edge_if;
   import pbg_pkg::*;
   logic [PORT_W-1:0] pins_sync;
   logic [IRQ_W-1:0] edge_sel;
   logic [IRQ_W-1:0] dir_low;
   logic [IRQ_W-1:0] events;
   modport core (input pins_sync, input events, output edge_sel, output dir_low);
   modport det (output pins_sync, output events, input edge_sel, input dir_low);
endinterface
`default_nettype wire

// ===== design/pbg_sampler.sv
// line sampler: two-flop synchroniser of all pins, edge detect on the low lines
// assumes pins are asynchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module pbg_sampler
   import pbg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [PORT_W-1:0] i_pin,
   pbg_edge_if.det edge_io
);
   logic [PORT_W-1:0] meta;
   logic [PORT_W-1:0] sync;
   logic [IRQ_W-1:0] prev;
   wire [IRQ_W-1:0] rise;
   wire [IRQ_W-1:0] fall;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= i_pin;
         sync <= meta;
         prev <= sync[IRQ_W-1:0];
      end
   end

   assign rise = sync[IRQ_W-1:0] & ~prev;
   assign fall = ~sync[IRQ_W-1:0] & prev;
   assign edge_io.pins_sync = sync;
   // per-line polarity, inputs only
   assign edge_io.events = ((edge_io.edge_sel & rise) | (~edge_io.edge_sel & fall)) & ~edge_io.dir_low;
endmodule
`default_nettype wire

// ===== design/pbg_port.sv
// sixteen-line general-purpose port with edge interrupts on the low eight lines
// assumes an AXI4-Lite master on i_clk and external pins wired to i_pin/o_pin/o_pin_oe
//
// Overview of operation
// - low eight lines, when inputs, raise an interrupt on a transition.
// - each low line selects rising or falling edge for its interrupt.
// - low eight lines also work as plain I/O with own direction bit.
// - next seven lines are plain I/O, each with own direction bit.
// - top line is plain I/O with own direction after the strap is taken.
// - after reset every line is an input with driver off.
// - pull-up on top line enabled during reset so open strap reads high.
// - strap low during reset selects low-frequency oscillator mode.
// - strap not low during reset selects default oscillator mode.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pbg_port
   import pbg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [STRB_W-1:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [PORT_W-1:0] i_pin,
   output logic [PORT_W-1:0] o_pin,
   output logic [PORT_W-1:0] o_pin_oe,
   output logic o_top_pullup,
   output logic o_osc_low_freq,
   output logic o_irq
);
   // ************************************
   // helpers
   // ************************************
   function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic is_word(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
      return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction

   // ************************************
   // state
   // ************************************
   logic [PORT_W-1:0] dir;
   logic [PORT_W-1:0] dout;
   logic [IRQ_W-1:0] edge_sel;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_stat;
   logic [1:0] strap_cnt;
   logic strap_done;
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [STRB_W-1:0] w_strb;

   pbg_edge_if edge_io ();

   pbg_sampler u_sampler (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_pin(i_pin),
      .edge_io(edge_io.det)
   );

   assign edge_io.edge_sel = edge_sel;
   assign edge_io.dir_low = dir[IRQ_W-1:0];

   // ************************************
   // write channel decode
   // ************************************
   wire aw_fire = i_awvalid & o_awready;
   wire w_fire = i_wvalid & o_wready;
   wire aw_have = aw_full | aw_fire;
   wire w_have = w_full | w_fire;
   wire do_write = aw_have & w_have & ~o_bvalid;
   wire [ADDR_W-1:0] wr_addr = aw_fire ? i_awaddr : aw_addr;
   wire [DATA_W-1:0] wr_data = w_fire ? i_wdata : w_data;
   wire [STRB_W-1:0] wr_strb = w_fire ? i_wstrb : w_strb;

   wire hit_w_dir = do_write & is_word(wr_addr, OFF_DIR);
   wire hit_w_dout = do_write & is_word(wr_addr, OFF_DOUT);
   wire hit_w_edge = do_write & is_word(wr_addr, OFF_EDGE_SEL);
   wire hit_w_mask = do_write & is_word(wr_addr, OFF_IRQ_MASK);
   wire hit_w_stat = do_write & is_word(wr_addr, OFF_IRQ_STAT);
   wire hit_w_ro = is_word(wr_addr, OFF_DIN) | is_word(wr_addr, OFF_OSC_STAT);
   wire wr_mapped = hit_w_dir | hit_w_dout | hit_w_edge | hit_w_mask | hit_w_stat | (do_write & hit_w_ro);

   wire [DATA_W-1:0] dir_merged = merge_strb({16'h0000, dir}, wr_data, wr_strb);
   wire [DATA_W-1:0] dout_merged = merge_strb({16'h0000, dout}, wr_data, wr_strb);
   wire [DATA_W-1:0] edge_merged = merge_strb({24'h000000, edge_sel}, wr_data, wr_strb);
   wire [DATA_W-1:0] mask_merged = merge_strb({24'h000000, irq_mask}, wr_data, wr_strb);
   wire [DATA_W-1:0] clr_merged = merge_strb('0, wr_data, wr_strb);
   wire [IRQ_W-1:0] stat_clr = hit_w_stat ? clr_merged[IRQ_W-1:0] : '0;

   wire [PORT_W-1:0] next_dir = hit_w_dir ? dir_merged[PORT_W-1:0] : dir;
   wire [PORT_W-1:0] next_dout = hit_w_dout ? dout_merged[PORT_W-1:0] : dout;
   wire [IRQ_W-1:0] next_edge_sel = hit_w_edge ? edge_merged[IRQ_W-1:0] : edge_sel;
   wire [IRQ_W-1:0] next_irq_mask = hit_w_mask ? mask_merged[IRQ_W-1:0] : irq_mask;

   // events before the sampler is primed are discarded
   wire [IRQ_W-1:0] events = strap_done ? edge_io.events : '0;
   // a new event wins over a clear in the same cycle
   wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~stat_clr) | events;
   // top line cannot drive until the strap is taken
   wire [PORT_W-1:0] drive_allow = strap_done ? {PORT_W{1'b1}} : ~TOP_MASK;

   wire next_aw_full = aw_have & ~do_write;
   wire next_w_full = w_have & ~do_write;
   wire next_bvalid = do_write | (o_bvalid & ~i_bready);

   // ************************************
   // read channel decode
   // ************************************
   wire ar_fire = i_arvalid & o_arready;
   wire next_rvalid = ar_fire | (o_rvalid & ~i_rready);
   wire rd_dir = is_word(i_araddr, OFF_DIR);
   wire rd_dout = is_word(i_araddr, OFF_DOUT);
   wire rd_din = is_word(i_araddr, OFF_DIN);
   wire rd_edge = is_word(i_araddr, OFF_EDGE_SEL);
   wire rd_mask = is_word(i_araddr, OFF_IRQ_MASK);
   wire rd_stat = is_word(i_araddr, OFF_IRQ_STAT);
   wire rd_osc = is_word(i_araddr, OFF_OSC_STAT);
   wire rd_mapped = rd_dir | rd_dout | rd_din | rd_edge | rd_mask | rd_stat | rd_osc;
   wire [DATA_W-1:0] osc_lf_word = DATA_W'(o_osc_low_freq) << OSC_LF_BIT;
   wire [DATA_W-1:0] osc_done_word = DATA_W'(strap_done) << OSC_DONE_BIT;
   wire [DATA_W-1:0] osc_word = osc_lf_word | osc_done_word;
   wire [DATA_W-1:0] rd_word =
      ({DATA_W{rd_dir}} & {16'h0000, dir}) |
      ({DATA_W{rd_dout}} & {16'h0000, dout}) |
      ({DATA_W{rd_din}} & {16'h0000, edge_io.pins_sync}) |
      ({DATA_W{rd_edge}} & {24'h000000, edge_sel}) |
      ({DATA_W{rd_mask}} & {24'h000000, irq_mask}) |
      ({DATA_W{rd_stat}} & {24'h000000, irq_stat}) |
      ({DATA_W{rd_osc}} & osc_word);

   // ************************************
   // bus slave registers
   // ************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_full <= 1'b0;
      end else begin
         aw_full <= next_aw_full;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         w_full <= 1'b0;
      end else begin
         w_full <= next_w_full;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_addr <= '0;
      end else if (aw_fire) begin
         aw_addr <= i_awaddr;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         w_data <= '0;
         w_strb <= '0;
      end else if (w_fire) begin
         w_data <= i_wdata;
         w_strb <= i_wstrb;
      end
   end

   // each ready drops while its own half is held or the response waits
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
      end else begin
         o_awready <= ~next_aw_full & ~next_bvalid;
         o_wready <= ~next_w_full & ~next_bvalid;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bvalid <= 1'b0;
      end else begin
         o_bvalid <= next_bvalid;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bresp <= RESP_OKAY;
      end else if (do_write) begin
         o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= ~next_rvalid;
         o_rvalid <= next_rvalid;
         if (ar_fire) begin
            o_rdata <= rd_word;
            o_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ************************************
   // port registers
   // ************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dir <= RST_DIR;
      end else begin
         dir <= next_dir;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dout <= RST_DOUT;
      end else begin
         dout <= next_dout;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         edge_sel <= RST_EDGE_SEL;
      end else begin
         edge_sel <= next_edge_sel;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_mask <= RST_IRQ_MASK;
      end else begin
         irq_mask <= next_irq_mask;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat <= RST_IRQ_STAT;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pin <= RST_DOUT;
      end else begin
         o_pin <= next_dout;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pin_oe <= RST_DIR;
      end else begin
         o_pin_oe <= next_dir & drive_allow;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(next_irq_stat & next_irq_mask);
      end
   end

   // ************************************
   // strap capture
   // ************************************
   // pull-up stays on through reset and until the synchronised level is taken
   wire strap_take = ~strap_done & (strap_cnt == STRAP_SAMPLE_CNT);
   wire [1:0] next_strap_cnt = (strap_done | strap_take) ? strap_cnt : strap_cnt + 2'h1;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_cnt <= '0;
      end else begin
         strap_cnt <= next_strap_cnt;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_done <= 1'b0;
      end else begin
         strap_done <= strap_done | strap_take;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_top_pullup <= 1'b1;
      end else begin
         o_top_pullup <= o_top_pullup & ~strap_take;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_osc_low_freq <= 1'b0;
      end else if (strap_take) begin
         o_osc_low_freq <= ~edge_io.pins_sync[TOP_LINE];
      end
   end
endmodule
`default_nettype wire

// ===== verif/pbg_pins_model.sv
// pin partner: outside drivers, the strap pull-up and the port drivers meet here
// assumes the port's o_pin/o_pin_oe and the testbench's external drive values
`timescale 1ns/10ps
`default_nettype none
module pbg_pins_model
   import pbg_pkg::*;
(
   input wire logic i_clk,
   input wire logic [PORT_W-1:0] i_out,
   input wire logic [PORT_W-1:0] i_oe,
   input wire logic [PORT_W-1:0] i_ext,
   input wire logic [PORT_W-1:0] i_ext_en,
   input wire logic i_pullup,
   output logic [PORT_W-1:0] o_line
);
   logic pat = 1'b0;
   always @(posedge i_clk) begin
      pat <= ~pat;
   end
   // undriven strap reads high, other floating lines wander
   always_comb begin
      for (int n = 0; n < PORT_W; n++) begin
         o_line[n] = i_oe[n] ? i_out[n] : i_ext_en[n] ? i_ext[n] : (n == TOP_LINE && i_pullup) ? 1'b1 : pat;
      end
   end
endmodule
`default_nettype wire

// ===== verif/pbg_port_sva.sv
// checker of the port top: reset state, strap capture and bus answer timing
// assumes one clock and an active-low reset
`timescale 1ns/10ps
`default_nettype none
module pbg_port_sva
   import pbg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic [PORT_W-1:0] i_pin,
   input wire logic [PORT_W-1:0] o_pin_oe,
   input wire logic o_top_pullup,
   input wire logic o_osc_low_freq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_taken;
      i_arvalid && o_arready;
   endsequence
   sequence s_strap_wait;
      o_top_pullup [*4] ##1 !o_top_pullup;
   endsequence
   a_oe_reset_off: assert property ($rose(i_nrst) |-> o_pin_oe == 16'h0000)
      else $error("line driver on after reset");
   a_pullup_release: assert property ($rose(i_nrst) |-> s_strap_wait)
      else $error("pull-up timing wrong");
   a_top_no_drive: assert property (o_top_pullup |-> !o_pin_oe[TOP_LINE])
      else $error("top line driven while strap active");
   a_strap_mode: assert property ($fell(o_top_pullup) |-> o_osc_low_freq == !$past(i_pin[TOP_LINE]))
      else $error("oscillator mode does not match strap");
   a_mode_held: assert property (!$past(o_top_pullup) |-> $stable(o_osc_low_freq))
      else $error("oscillator mode changed");
   a_wr_answer: assert property (s_wr_taken |=> o_bvalid)
      else $error("write response late");
   a_wr_busy: assert property (s_wr_taken |=> !o_awready && !o_wready)
      else $error("write accepted while busy");
   a_rd_answer: assert property (s_rd_taken |=> o_rvalid && !o_arready)
      else $error("read response late");
endmodule
bind pbg_port pbg_port_sva u_sva (.i_clk, .i_nrst, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
   .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .i_pin, .o_pin_oe, .o_top_pullup, .o_osc_low_freq);
`default_nettype wire

// ===== verif/pbg_port_tb.sv
// testbench of the port: bus tasks, pin partner, one task a scenario
// assumes pbg_pins_model on the pins and the bound checker
`timescale 1ns/10ps
`default_nettype none
module pbg_port_tb;
   import pbg_pkg::*;
   logic i_clk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [ADDR_W-1:0] i_awaddr, i_araddr;
   logic [DATA_W-1:0] i_wdata, o_rdata;
   logic [STRB_W-1:0] i_wstrb;
   logic [PORT_W-1:0] i_pin, o_pin, o_pin_oe, ext, ext_en;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_top_pullup, o_osc_low_freq, o_irq;
   logic [1:0] o_bresp, o_rresp;
   int err_count, cmp_count;
   pbg_port u_dut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
      .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
      .o_rvalid, .i_rready, .i_pin, .o_pin, .o_pin_oe, .o_top_pullup, .o_osc_low_freq, .o_irq);
   pbg_pins_model u_pins (.i_clk, .i_out(o_pin), .i_oe(o_pin_oe), .i_ext(ext), .i_ext_en(ext_en),
      .i_pullup(o_top_pullup), .o_line(i_pin));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk(o_bresp, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      chk(o_rdata, e);
      chk(o_rresp, r);
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_reset();
      chk(o_pin_oe, 16'h0000);
      chk(o_top_pullup, 1'b1);
      repeat (8) @(posedge i_clk);
      chk(o_osc_low_freq, 1'b0);
      chk(o_top_pullup, 1'b0);
      rd(OFF_OSC_STAT, 32'h2, RESP_OKAY);
      rd(OFF_DIR, 32'h0, RESP_OKAY);
      rd(OFF_EDGE_SEL, 32'h0, RESP_OKAY);
      rd(8'h1c, 32'h0, RESP_SLVERR);
      wr(8'h1c, 32'h1, RESP_SLVERR);
      $display("reset test done");
   endtask
   task automatic t_dir();
      ext_en <= 16'h0000;
      wr(OFF_DIR, 32'hffff);
      wr(OFF_DOUT, 32'ha5c3);
      chk(o_pin_oe, 16'hffff);
      chk(o_pin, 16'ha5c3);
      repeat (3) @(posedge i_clk);
      rd(OFF_DIN, 32'ha5c3, RESP_OKAY);
      wr(OFF_DIR, 32'h0);
      ext_en <= 16'hffff;
      $display("direction test done");
   endtask
   task automatic t_irq();
      ext <= 16'h00f0;
      wr(OFF_EDGE_SEL, 32'h0f);
      wr(OFF_IRQ_MASK, 32'hff);
      wr(OFF_IRQ_STAT, 32'hff);
      rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      ext <= 16'h000f;
      repeat (5) @(posedge i_clk);
      chk(o_irq, 1'b1);
      rd(OFF_IRQ_STAT, 32'hff, RESP_OKAY);
      wr(OFF_IRQ_STAT, 32'hff);
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'b0);
      // reverse transitions must stay quiet
      ext <= 16'h00f0;
      repeat (5) @(posedge i_clk);
      rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      wr(OFF_IRQ_MASK, 32'h0);
      ext <= 16'h000f;
      repeat (5) @(posedge i_clk);
      chk(o_irq, 1'b0);
      rd(OFF_IRQ_STAT, 32'hff, RESP_OKAY);
      wr(OFF_DIR, 32'hff);
      ext_en <= 16'hff00;
      wr(OFF_IRQ_STAT, 32'hff);
      wr(OFF_DOUT, 32'h0);
      wr(OFF_DOUT, 32'hff);
      repeat (5) @(posedge i_clk);
      rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
      $display("interrupt test done");
   endtask
   task automatic t_strap();
      ext <= 16'h0000;
      ext_en <= 16'hffff;
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      // top line direction set while the strap is still being taken
      wr(OFF_DIR, 32'h8000);
      repeat (8) @(posedge i_clk);
      chk(o_osc_low_freq, 1'b1);
      rd(OFF_OSC_STAT, 32'h3, RESP_OKAY);
      ext <= 16'h8000;
      chk(o_pin_oe, 16'h8000);
      chk(o_osc_low_freq, 1'b1);
      repeat (3) @(posedge i_clk);
      rd(OFF_DIN, 32'h0, RESP_OKAY);
      $display("strap test done");
   endtask
   initial begin
      i_nrst = 1'b0;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      {i_awaddr, i_araddr, i_wdata} = '0;
      i_wstrb = 4'hf;
      ext = 16'h00f0;
      ext_en = 16'h7fff;
      err_count = 0;
      cmp_count = 0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_reset();
      t_dir();
      t_irq();
      t_strap();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
